// ### src/uhb_pkg.sv
// Package for the host bus port: constants and carriers
package uhb_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 8;
  localparam int INT_OPEN_SRC_BIT = 5;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
  localparam logic [7:0] MCR_ADDR = 8'h04;
  localparam int SYNC_STAGES = 2;

  // Raw pin group sampled from the host bus
  typedef struct packed {
    logic read_strobe_lo;
    logic read_strobe_hi;
    logic write_strobe_lo;
    logic write_strobe_hi;
    logic select_hi_a;
    logic select_hi_b;
    logic select_lo;
    logic address_latch_strobe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } uhb_pins_t;

  // Register-side access request toward the UART core
  typedef struct packed {
    logic rd_pulse;
    logic wr_pulse;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } uhb_req_t;

  // Status presented by the UART core
  typedef struct packed {
    logic tx_irq;
    logic rx_irq;
    logic line_irq;
    logic modem_irq;
    logic tx_space;
    logic rx_avail;
  } uhb_stat_t;

  localparam int PIN_W = $bits(uhb_pins_t);

endpackage : uhb_pkg

// ### src/uhb_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module uhb_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // First stage is read only by the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '0;
      q <= '0;
    end else if (ce) begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule : uhb_sync

// ### src/uhb_port.sv
// Separate-strobe parallel host bus port of a FIFO UART
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [R1] Host ties bus-mode select high for this mode
// [R2] Low three address lines pick the register
// [R3] Read strobe fall reads addressed register onto bus
// [R4] Active-high read strobe equals active-low one
// [R5] Write latches data-bus byte on trailing edge
// [R6] Active-high write strobe equals active-low one
// [R7] Respond only with all three selects active
// [R8] Host holds unused selects at active level
// [R9] Host holds unused strobes inactive for power
// [R10] Interrupt high on any source condition
// [R11] Control bit 5 picks push-pull or open-source
// [R12] Address strobe fall latches selects and address; the code keeps following the pins until a strobe shows
// [R13] Address latched even with strobe tied low
// [R14] Active-low transmit-ready flag from core status
// [R15] Active-low receive-ready flag from core status
// [R16] Data bus driven only during selected read
module uhb_port (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic read_strobe_lo,
  input wire logic read_strobe_hi,
  input wire logic write_strobe_lo,
  input wire logic write_strobe_hi,
  input wire logic select_hi_a,
  input wire logic select_hi_b,
  input wire logic select_lo,
  input wire logic address_latch_strobe_n,
  input wire logic [uhb_pkg::ADDR_W-1:0] addr,
  input wire logic [uhb_pkg::DATA_W-1:0] data_in,
  output logic [uhb_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire uhb_pkg::uhb_stat_t core_stat,
  input wire logic [uhb_pkg::DATA_W-1:0] core_rdata,
  output uhb_pkg::uhb_req_t core_req,
  output logic irq_out,
  output logic irq_oe,
  output logic tx_space_flag_n,
  output logic rx_avail_flag_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  uhb_pkg::uhb_pins_t pins_raw;
  uhb_pkg::uhb_pins_t pins;

  assign pins_raw = '{
    read_strobe_lo: read_strobe_lo,
    read_strobe_hi: read_strobe_hi,
    write_strobe_lo: write_strobe_lo,
    write_strobe_hi: write_strobe_hi,
    select_hi_a: select_hi_a,
    select_hi_b: select_hi_b,
    select_lo: select_lo,
    address_latch_strobe_n: address_latch_strobe_n,
    addr: addr,
    data: data_in
  };

  uhb_sync #(.W(uhb_pkg::PIN_W)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .d(pins_raw),
    .q(pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decode

  logic rd_act;
  logic wr_act;
  logic sel_now;
  logic as_low;
  logic rd_act_ff;
  logic wr_act_ff;
  logic as_low_ff;
  logic rd_rise;
  logic wr_rise;
  logic wr_fall;
  logic as_fall;

  assign rd_act = !pins.read_strobe_lo || pins.read_strobe_hi; // [R4]
  assign wr_act = !pins.write_strobe_lo || pins.write_strobe_hi; // [R6]
  assign sel_now = pins.select_hi_a && pins.select_hi_b && !pins.select_lo; // [R7]
  assign as_low = !pins.address_latch_strobe_n;
  assign rd_rise = rd_act && !rd_act_ff;
  assign wr_rise = wr_act && !wr_act_ff;
  assign wr_fall = !wr_act && wr_act_ff;
  assign as_fall = as_low && !as_low_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_act_ff <= 1'b0;
      wr_act_ff <= 1'b0;
      as_low_ff <= 1'b0;
    end else if (ce) begin
      rd_act_ff <= rd_act;
      wr_act_ff <= wr_act;
      as_low_ff <= as_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and select latch

  logic [uhb_pkg::ADDR_W-1:0] addr_lat_ff;
  logic sel_lat_ff;
  logic [uhb_pkg::ADDR_W-1:0] nxt_addr_lat;
  logic nxt_sel_lat;
  logic access_open;

  assign access_open = rd_act || wr_act;

  // Follow the pins until an access opens, so a tied-low strobe still
  // yields an address held for the whole access
  always_comb begin
    nxt_addr_lat = addr_lat_ff;
    nxt_sel_lat = sel_lat_ff;
    if (as_fall) begin
      nxt_addr_lat = pins.addr; // [R12]
      nxt_sel_lat = sel_now; // [R12]
    end else if (!rd_act_ff && !wr_act_ff) begin
      // Track through the edge where a strobe first shows, since address and
      // strobe leave the synchroniser together
      if (!as_low || as_low_ff) begin
        nxt_addr_lat = pins.addr; // [R13]
        nxt_sel_lat = sel_now; // [R13]
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_lat_ff <= uhb_pkg::ADDR_RST;
      sel_lat_ff <= 1'b0;
    end else if (ce) begin
      addr_lat_ff <= nxt_addr_lat;
      sel_lat_ff <= nxt_sel_lat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access state machine

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} uhb_state_t;

  uhb_state_t state_ff;
  uhb_state_t nxt_state;
  logic [uhb_pkg::DATA_W-1:0] wdata_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (rd_rise && nxt_sel_lat) begin
          nxt_state = ST_READ; // [R3]
        end else if (wr_rise && nxt_sel_lat) begin
          nxt_state = ST_WRITE; // [R5]
        end
      end
      ST_READ: begin
        if (!rd_act) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (!wr_act) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // Data keeps following the bus while the write strobe is active so the
  // value present at the trailing edge is the one stored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdata_ff <= uhb_pkg::DATA_RST;
    end else if (ce && wr_act) begin
      wdata_ff <= pins.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests to the core

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_req <= '0;
    end else if (ce) begin
      core_req.rd_pulse <= (state_ff == ST_IDLE) && rd_rise && nxt_sel_lat; // [R3]
      core_req.wr_pulse <= (state_ff == ST_WRITE) && wr_fall; // [R5]
      core_req.addr <= nxt_addr_lat; // [R2]
      core_req.wdata <= wdata_ff; // [R5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data drive

  logic rd_drive;

  assign rd_drive = (state_ff == ST_READ) && rd_act;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= uhb_pkg::DATA_RST;
      data_oe <= 1'b0;
    end else if (ce) begin
      data_oe <= rd_drive; // [R16]
      if (rd_drive) begin
        data_out <= core_rdata; // [R3]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and ready flags

  logic irq_any;
  logic open_src_ff;

  assign irq_any = core_stat.tx_irq || core_stat.rx_irq ||
                   core_stat.line_irq || core_stat.modem_irq; // [R10]

  // Shadow of the modem control bit that picks the interrupt drive style
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      open_src_ff <= 1'b0;
    end else if (ce && (state_ff == ST_WRITE) && wr_fall &&
                 ({5'h00, addr_lat_ff} == uhb_pkg::MCR_ADDR)) begin
      open_src_ff <= wdata_ff[uhb_pkg::INT_OPEN_SRC_BIT]; // [R11]
    end
  end

  // Open-source mode drives only the high level; a resistor pulls low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_out <= 1'b0;
      irq_oe <= 1'b1;
    end else if (ce) begin
      irq_out <= irq_any; // [R10]
      irq_oe <= open_src_ff ? irq_any : 1'b1; // [R11]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_space_flag_n <= 1'b1;
      rx_avail_flag_n <= 1'b1;
    end else if (ce) begin
      tx_space_flag_n <= !core_stat.tx_space; // [R14]
      rx_avail_flag_n <= !core_stat.rx_avail; // [R15]
    end
  end

endmodule : uhb_port

// ### test/uhb_port_properties.sv
// Timing checks on the host bus port
`timescale 1ns/100ps
module uhb_port_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic read_strobe_lo,
  input wire logic read_strobe_hi,
  input wire logic write_strobe_lo,
  input wire logic write_strobe_hi,
  input wire logic select_hi_a,
  input wire logic select_hi_b,
  input wire logic select_lo,
  input wire logic [uhb_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire uhb_pkg::uhb_stat_t core_stat,
  input wire logic [uhb_pkg::DATA_W-1:0] core_rdata,
  input wire uhb_pkg::uhb_req_t core_req,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic tx_space_flag_n,
  input wire logic rx_avail_flag_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic rd, wr, rs, ws, anyi;
  logic [1:0] fl;
  assign rd = !read_strobe_lo || read_strobe_hi;
  assign wr = !write_strobe_lo || write_strobe_hi;
  assign rs = rd && select_hi_a && select_hi_b && !select_lo;
  assign ws = wr && select_hi_a && select_hi_b && !select_lo;
  assign anyi = |core_stat[5:2];
  assign fl = {core_stat.tx_space, core_stat.rx_avail};
  ////////////////////////////////////////
  property p_dat; $rose(data_oe) |-> data_out == $past(core_rdata); endproperty
  a_dat: assert property (p_dat) else $error("read byte wrong");
  property p_one; $rose(data_oe) |-> $past(core_req.rd_pulse); endproperty
  a_one: assert property (p_one) else $error("bus driven before read");
  property p_oe; data_oe |-> $past(rs, 3); endproperty
  a_oe: assert property (p_oe) else $error("bus driven outside read");
  property p_rdp; core_req.rd_pulse |-> $past(rs, 3) && !$past(rd, 4); endproperty
  a_rdp: assert property (p_rdp) else $error("read pulse wrong");
  property p_wrp; core_req.wr_pulse |-> $past(ws, 4) && !$past(wr, 3); endproperty
  a_wrp: assert property (p_wrp) else $error("write pulse wrong");
  property p_irq; ce |=> irq_out == $past(anyi); endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
  property p_ios; irq_out |-> irq_oe; endproperty
  a_ios: assert property (p_ios) else $error("interrupt not driven");
  property p_flg; ce |=> {tx_space_flag_n, rx_avail_flag_n} == ~$past(fl); endproperty
  a_flg: assert property (p_flg) else $error("ready flags wrong");
endmodule : uhb_port_properties

bind uhb_port uhb_port_properties u_props (.*);

// ### test/uhb_host.sv
// Host processor model on the separate-strobe bus
`timescale 1ns/100ps
module uhb_host (
  input wire logic clk,
  input wire logic data_oe,
  input wire logic [uhb_pkg::DATA_W-1:0] data_out,
  output uhb_pkg::uhb_pins_t pins
);
  // Address strobe stays low: the port must latch the address itself
  initial begin
    pins = '0;
    pins.read_strobe_lo = 1'b1;
    pins.write_strobe_lo = 1'b1;
    pins.select_hi_a = 1'b1;
    pins.select_hi_b = 1'b1;
  end
  ////////////////////////////////////////
  task automatic xfer(input logic wr, input logic hi, input logic [2:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic seen);
    q = 'x;
    seen = 1'b0;
    @(posedge clk);
    #1;
    pins.addr = a;
    pins.data = d;
    pins.read_strobe_lo = wr | hi;
    pins.read_strobe_hi = !wr & hi;
    pins.write_strobe_lo = !wr | hi;
    pins.write_strobe_hi = wr & hi;
    for (int i = 0; i < 8 && !seen; i++) begin
      @(posedge clk);
      #1;
      if (!wr && data_oe === 1'b1) begin
        seen = 1'b1;
        q = data_out;
      end
      // Moving the address mid-access proves the latch
      if (i == 1) pins.addr = ~a;
    end
    pins.read_strobe_lo = 1'b1;
    pins.read_strobe_hi = 1'b0;
    pins.write_strobe_lo = 1'b1;
    pins.write_strobe_hi = 1'b0;
    pins.data = ~d;
  endtask : xfer
endmodule : uhb_host

// ### test/test_uart_host_bus_port.sv
// Self-checking bench for the host bus port
`timescale 1ns/100ps
module test_uart_host_bus_port;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  uhb_pkg::uhb_stat_t core_stat = '0;
  uhb_pkg::uhb_pins_t pins;
  uhb_pkg::uhb_req_t core_req;
  logic [7:0] data_out, core_rdata, data_in, q, wd;
  logic [2:0] wa;
  logic data_oe, irq_out, irq_oe, txf_n, rxf_n, seen;
  int n_mismatch = 0;
  int compares = 0;
  int nr = 0;
  int nw = 0;
  always #2.5 clk = ~clk;
  assign core_rdata = {5'h15, core_req.addr};
  assign data_in = data_oe ? data_out : pins.data;
  always @(posedge clk) begin
    nr <= nr + (core_req.rd_pulse === 1'b1);
    if (core_req.wr_pulse === 1'b1) begin
      nw <= nw + 1;
      wa <= core_req.addr;
      wd <= core_req.wdata;
    end
  end
  uhb_host u_host (.clk(clk), .data_oe(data_oe), .data_out(data_out), .pins(pins));
  uhb_port dut (.clk(clk), .arst_n(arst_n), .ce(ce), .read_strobe_lo(pins.read_strobe_lo),
    .read_strobe_hi(pins.read_strobe_hi), .write_strobe_lo(pins.write_strobe_lo),
    .write_strobe_hi(pins.write_strobe_hi), .select_hi_a(pins.select_hi_a),
    .select_hi_b(pins.select_hi_b), .select_lo(pins.select_lo),
    .address_latch_strobe_n(pins.address_latch_strobe_n), .addr(pins.addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .core_stat(core_stat),
    .core_rdata(core_rdata), .core_req(core_req), .irq_out(irq_out), .irq_oe(irq_oe),
    .tx_space_flag_n(txf_n), .rx_avail_flag_n(rxf_n));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic t_read;
    int b;
    for (int k = 0; k < 4; k++) begin
      b = nr;
      u_host.xfer(1'b0, k[0], 3'(k * 5), 8'h00, q, seen);
      tick(6);
      chk(q, {5'h15, 3'(k * 5)});
      chk(8'(nr - b), 8'h01);
    end
  endtask : t_read
  task automatic t_write;
    int b;
    for (int k = 0; k < 2; k++) begin
      b = nw;
      u_host.xfer(1'b1, k[0], 3'h5, 8'hA5 ^ 8'(k), q, seen);
      tick(6);
      chk(8'(nw - b), 8'h01);
      chk({5'h00, wa}, 8'h05);
      chk(wd, 8'hA5 ^ 8'(k));
    end
  endtask : t_write
  task automatic t_refuse;
    int b;
    for (int k = 0; k < 3; k++) begin
      b = nr + nw;
      u_host.pins.select_hi_a = (k != 0);
      u_host.pins.select_hi_b = (k != 1);
      u_host.pins.select_lo = (k == 2);
      u_host.xfer(k[0], 1'b0, 3'h1, 8'h3C, q, seen);
      tick(6);
      u_host.pins = {4'hA, 4'hC, 11'h000};
      chk({7'h00, seen}, 8'h00);
      chk(8'(nr + nw - b), 8'h00);
    end
  endtask : t_refuse
  task automatic t_irq;
    for (int k = 0; k < 4; k++) begin
      core_stat = uhb_pkg::uhb_stat_t'(6'h04 << k);
      tick(2);
      chk({irq_out, irq_oe}, 8'h03);
      core_stat = '0;
      tick(2);
      chk({irq_out, irq_oe}, 8'h01);
    end
    u_host.xfer(1'b1, 1'b0, uhb_pkg::MCR_ADDR[2:0], 8'h20, q, seen);
    tick(6);
    chk({irq_out, irq_oe}, 8'h00);
    core_stat.line_irq = 1'b1;
    tick(2);
    chk({irq_out, irq_oe}, 8'h03);
  endtask : t_irq
  task automatic t_flags;
    for (int k = 0; k < 4; k++) begin
      core_stat = uhb_pkg::uhb_stat_t'(k);
      tick(2);
      chk({txf_n, rxf_n}, 8'(3 - k));
    end
    // Clock enable low must freeze the registered flags
    ce = 1'b0;
    core_stat = '0;
    tick(2);
    chk({txf_n, rxf_n}, 8'h00);
    ce = 1'b1;
    tick(2);
    chk({txf_n, rxf_n}, 8'h03);
  endtask : t_flags
  task automatic close_out;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  initial begin
    tick(4);
    arst_n = 1'b1;
    tick(3);
    t_read();
    t_write();
    t_refuse();
    t_irq();
    t_flags();
    close_out();
  end
  initial begin
    #50000;
    n_mismatch++;
    close_out();
  end
endmodule : test_uart_host_bus_port
